/* core/sbt_pkg.sv */
// constants and types shared by the scan test port
package sbt_pkg;

	// =====================================================================
	// controller states
	// =====================================================================
	typedef enum logic [3:0]
	{
		ST_RESET,
		ST_IDLE,
		ST_SEL_DR,
		ST_CAP_DR,
		ST_SHIFT_DR,
		ST_EXIT1_DR,
		ST_PAUSE_DR,
		ST_EXIT2_DR,
		ST_UPD_DR,
		ST_SEL_IR,
		ST_CAP_IR,
		ST_SHIFT_IR,
		ST_EXIT1_IR,
		ST_PAUSE_IR,
		ST_EXIT2_IR,
		ST_UPD_IR
	} sbt_state_t;

	// =====================================================================
	// register widths and instruction codes
	// =====================================================================
	localparam int         IR_WIDTH       = 3;
	localparam int         ID_WIDTH       = 32;
	localparam logic [2:0] INS_EXT_TEST   = 3'h0;   // all zeros
	localparam logic [2:0] INS_IDENT      = 3'h1;
	localparam logic [2:0] INS_SAMPLE_Z   = 3'h2;
	localparam logic [2:0] INS_SAMPLE     = 3'h4;
	localparam logic [2:0] INS_BYPASS     = 3'h7;   // all ones
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;   // fixed capture pattern
	localparam logic       IR_CAPTURE_MSB = 1'h0;
	localparam logic       BYPASS_CAPTURE = 1'h0;

	// =====================================================================
	// reset and crossing figures
	// =====================================================================
	localparam int         RESET_TMS_EDGES = 5;     // tms high edges to reach reset
	localparam logic       TDO_OE_RESET    = 1'h0;
	localparam logic       TDO_RESET       = 1'h0;
	localparam logic       FLOAT_RESET     = 1'h0;

endpackage

/* core/sbt_sync.sv */
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps

module sbt_sync
#(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	// clock and reset of the receiving domain
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// level from the other domain
	input  wire logic [WIDTH-1:0] d_in,
	// synchronised level
	output logic      [WIDTH-1:0] q_out
);

	// =====================================================================
	// two stages; only the second stage reads the first
	// =====================================================================
	logic [WIDTH-1:0] first_reg;
	logic [WIDTH-1:0] first_next;
	logic [WIDTH-1:0] second_reg;
	logic [WIDTH-1:0] second_next;

	// next values, synchronous reset to the given constant
	always_comb
	begin
		first_next  = rst_in ? RESET_VALUE : d_in;
		second_next = rst_in ? RESET_VALUE : first_reg;
	end

	// register stage
	always_ff @(posedge clk_in)
	begin
		first_reg  <= first_next;
		second_reg <= second_next;
	end

	assign q_out = second_reg;

endmodule // sbt_sync

/* core/sbt_tap.sv */
// boundary scan test access port of a synchronous burst memory
`timescale 1ns/1ps

// How it works
// - inputs sampled on test clock rise; serial output changes only on its fall.
// - mode select sampled each rise; board pull-up makes a floating input high.
// - controller follows the standard sixteen-state diagram driven by mode select.
// - serial input enters the msb of the selected register; shifts toward lsb.
// - serial output shows selected lsb, driven only while shifting, else floated.
// - one register sits in the path, chosen by the current instruction.
// - five high mode-select edges reset the port without touching the memory.
// - power-up resets the port internally so the serial output starts floated.
// - instruction register is three bits, loaded serially while selected.
// - instruction becomes identify at power-up and in test-logic reset.
// - capture-ir loads binary 01 into the two instruction lsbs.
// - bypass is one bit, cleared on capture, a one-stage path.
// - boundary register has one cell per scanned ball, msb at input.
// - boundary register snapshots the ring on capture, shifts in shift-dr.
// - external test, sample and sample-float all select and capture the ring.
// - reserved codes fall back to bypass so shared chains stay intact.
// - identify instruction captures a fixed 32-bit code and shifts it out.
// - all-zero code acts as sample but also floats the memory outputs.
// - sample-float selects the boundary register and floats memory outputs.

module sbt_tap
	import sbt_pkg::*;
#(
	parameter int                  BSR_LEN = 72,             // scanned ball count
	parameter logic [ID_WIDTH-1:0] ID_CODE = 32'h0a5c_3e01    // value is arbitrary
)
(
	// system clock and reset
	input  wire logic               CLOCK_IN,
	input  wire logic               RESET_IN,
	// scan link, clocked by the scan controller
	input  wire logic               TCK_IN,
	input  wire logic               TMS_IN,
	input  wire logic               TDI_IN,
	output logic                    TDO_OUT,
	output logic                    TDO_OE_OUT,
	// memory i/o ring, system clock side
	input  wire logic [BSR_LEN-1:0] RING_IN,
	output logic                    FLOAT_OUTPUTS_OUT
);

	// =====================================================================
	// crossings into the test clock domain
	// =====================================================================
	logic               tap_rst;
	logic [BSR_LEN-1:0] ring_sync;

	// system reset doubles as the power-up reset of the port
	sbt_sync #(.WIDTH(1), .RESET_VALUE(1'h1)) u_rst_sync
	(
		.clk_in (TCK_IN),
		.rst_in (1'h0),
		.d_in   (RESET_IN),
		.q_out  (tap_rst)
	);

	// ring levels change on the fast clock; capture only sees settled bits
	sbt_sync #(.WIDTH(BSR_LEN), .RESET_VALUE('0)) u_ring_sync
	(
		.clk_in (TCK_IN),
		.rst_in (tap_rst),
		.d_in   (RING_IN),
		.q_out  (ring_sync)
	);

	// =====================================================================
	// controller state machine
	// =====================================================================
	sbt_state_t state_reg;
	sbt_state_t state_next;

	// mode select is read only here, at the rising edge
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RESET:    state_next = TMS_IN ? ST_RESET   : ST_IDLE;
			ST_IDLE:     state_next = TMS_IN ? ST_SEL_DR  : ST_IDLE;
			ST_SEL_DR:   state_next = TMS_IN ? ST_SEL_IR  : ST_CAP_DR;
			ST_CAP_DR:   state_next = TMS_IN ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_next = TMS_IN ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: state_next = TMS_IN ? ST_UPD_DR  : ST_PAUSE_DR;
			ST_PAUSE_DR: state_next = TMS_IN ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: state_next = TMS_IN ? ST_UPD_DR  : ST_SHIFT_DR;
			ST_UPD_DR:   state_next = TMS_IN ? ST_SEL_DR  : ST_IDLE;
			ST_SEL_IR:   state_next = TMS_IN ? ST_RESET   : ST_CAP_IR;
			ST_CAP_IR:   state_next = TMS_IN ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: state_next = TMS_IN ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: state_next = TMS_IN ? ST_UPD_IR  : ST_PAUSE_IR;
			ST_PAUSE_IR: state_next = TMS_IN ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: state_next = TMS_IN ? ST_UPD_IR  : ST_SHIFT_IR;
			ST_UPD_IR:   state_next = TMS_IN ? ST_SEL_DR  : ST_IDLE;
		endcase
		if (tap_rst)
		begin
			state_next = ST_RESET;
		end
	end

	// inputs are taken on the rising edge only
	always_ff @(posedge TCK_IN)
	begin
		state_reg <= state_next;
	end

	// =====================================================================
	// instruction register
	// =====================================================================
	logic [IR_WIDTH-1:0] ir_shift_reg;
	logic [IR_WIDTH-1:0] ir_shift_next;
	logic [IR_WIDTH-1:0] ir_reg;
	logic [IR_WIDTH-1:0] ir_next;

	// capture the fixed pattern, shift lsb-first, apply on update
	always_comb
	begin
		ir_shift_next = ir_shift_reg;
		ir_next       = ir_reg;
		unique case (state_reg)
			ST_RESET:    ir_next = INS_IDENT;
			ST_CAP_IR:   ir_shift_next = {IR_CAPTURE_MSB, IR_CAPTURE_LOW};
			ST_SHIFT_IR: ir_shift_next = {TDI_IN, ir_shift_reg[IR_WIDTH-1:1]};
			ST_UPD_IR:   ir_next = ir_shift_reg;
			default:     ir_next = ir_reg;
		endcase
		if (tap_rst)
		begin
			ir_shift_next = {IR_CAPTURE_MSB, IR_CAPTURE_LOW};
			ir_next       = INS_IDENT;
		end
	end

	// register stage
	always_ff @(posedge TCK_IN)
	begin
		ir_shift_reg <= ir_shift_next;
		ir_reg       <= ir_next;
	end

	// =====================================================================
	// data register selection
	// =====================================================================
	logic sel_bsr;
	logic sel_id;

	// reserved codes get the one-bit bypass so a shared chain keeps its length
	always_comb
	begin
		sel_bsr = (ir_reg == INS_EXT_TEST) || (ir_reg == INS_SAMPLE)
			|| (ir_reg == INS_SAMPLE_Z);
		sel_id  = (ir_reg == INS_IDENT);
	end

	// =====================================================================
	// data registers: boundary, identify, bypass
	// =====================================================================
	logic [BSR_LEN-1:0]  bsr_reg;
	logic [BSR_LEN-1:0]  bsr_next;
	logic [ID_WIDTH-1:0] id_reg;
	logic [ID_WIDTH-1:0] id_next;
	logic                bypass_reg;
	logic                bypass_next;

	// only the selected register moves; there is no preload stage
	always_comb
	begin
		bsr_next    = bsr_reg;
		id_next     = id_reg;
		bypass_next = bypass_reg;
		if (state_reg == ST_CAP_DR)
		begin
			if (sel_bsr)
			begin
				bsr_next = ring_sync;
			end
			else if (sel_id)
			begin
				id_next = ID_CODE;
			end
			else
			begin
				bypass_next = BYPASS_CAPTURE;
			end
		end
		else if (state_reg == ST_SHIFT_DR)
		begin
			if (sel_bsr)
			begin
				bsr_next = {TDI_IN, bsr_reg[BSR_LEN-1:1]};
			end
			else if (sel_id)
			begin
				id_next = {TDI_IN, id_reg[ID_WIDTH-1:1]};
			end
			else
			begin
				bypass_next = TDI_IN;
			end
		end
		if (tap_rst)
		begin
			bsr_next    = '0;
			id_next     = ID_CODE;
			bypass_next = BYPASS_CAPTURE;
		end
	end

	// register stage
	always_ff @(posedge TCK_IN)
	begin
		bsr_reg    <= bsr_next;
		id_reg     <= id_next;
		bypass_reg <= bypass_next;
	end

	// =====================================================================
	// serial output, falling edge
	// =====================================================================
	logic shifting;
	logic tdo_src;
	logic tdo_reg;
	logic tdo_next;
	logic tdo_oe_reg;
	logic tdo_oe_next;

	// the far end samples on the rise, so half a period of margin is given
	always_comb
	begin
		shifting = (state_reg == ST_SHIFT_DR) || (state_reg == ST_SHIFT_IR);
		if (state_reg == ST_SHIFT_IR)
		begin
			tdo_src = ir_shift_reg[0];
		end
		else if (sel_bsr)
		begin
			tdo_src = bsr_reg[0];
		end
		else if (sel_id)
		begin
			tdo_src = id_reg[0];
		end
		else
		begin
			tdo_src = bypass_reg;
		end
		tdo_next    = shifting ? tdo_src : tdo_reg;
		tdo_oe_next = shifting;
		if (tap_rst)
		begin
			tdo_next    = TDO_RESET;
			tdo_oe_next = TDO_OE_RESET;
		end
	end

	// output flops change only on the falling edge
	always_ff @(negedge TCK_IN)
	begin
		tdo_reg    <= tdo_next;
		tdo_oe_reg <= tdo_oe_next;
	end

	assign TDO_OUT    = tdo_reg;
	assign TDO_OE_OUT = tdo_oe_reg;

	// =====================================================================
	// output float request, crossed to the system clock
	// =====================================================================
	logic float_req_reg;
	logic float_req_next;
	logic float_sync;
	logic float_reg;
	logic float_next;

	// requested while the current instruction floats the memory outputs
	always_comb
	begin
		float_req_next = tap_rst ? FLOAT_RESET
			: ((ir_reg == INS_EXT_TEST) || (ir_reg == INS_SAMPLE_Z));
	end

	// register stage
	always_ff @(posedge TCK_IN)
	begin
		float_req_reg <= float_req_next;
	end

	// level crossing; a few system clocks of lag are harmless here
	sbt_sync #(.WIDTH(1), .RESET_VALUE(FLOAT_RESET)) u_float_sync
	(
		.clk_in (CLOCK_IN),
		.rst_in (RESET_IN),
		.d_in   (float_req_reg),
		.q_out  (float_sync)
	);

	// registered output on the system clock
	always_comb
	begin
		float_next = RESET_IN ? FLOAT_RESET : float_sync;
	end

	// register stage
	always_ff @(posedge CLOCK_IN)
	begin
		float_reg <= float_next;
	end

	assign FLOAT_OUTPUTS_OUT = float_reg;

	// =====================================================================
	// assertions
	// =====================================================================
	default clocking cb_tck @(posedge TCK_IN);
	endclocking
	default disable iff (tap_rst);

	sequence s_tms_held;
		TMS_IN [*5];
	endsequence

	sequence s_idle_hold;
		(state_reg == ST_IDLE) && !TMS_IN;
	endsequence

	a_tms_reset: assert property (s_tms_held |=> state_reg == ST_RESET)
		else $error("five high mode-select edges did not reach reset");

	a_idle_hold: assert property (s_idle_hold |=> state_reg == ST_IDLE)
		else $error("idle left with mode select low");

	a_ir_capture: assert property ((state_reg == ST_CAP_IR)
		|=> ir_shift_reg[1:0] == IR_CAPTURE_LOW)
		else $error("instruction capture pattern wrong");

	a_ir_reset: assert property ((state_reg == ST_RESET)
		|=> ir_reg == INS_IDENT)
		else $error("instruction not identify after reset state");

	a_ir_shift: assert property ((state_reg == ST_SHIFT_IR)
		|=> ir_shift_reg[IR_WIDTH-1] == $past(TDI_IN)
		&& ir_shift_reg[0] == $past(ir_shift_reg[1]))
		else $error("instruction shift path broken");

	a_bypass_clear: assert property ((state_reg == ST_CAP_DR) && !sel_bsr && !sel_id
		|=> bypass_reg == BYPASS_CAPTURE)
		else $error("bypass not cleared on capture");

	a_id_capture: assert property ((state_reg == ST_CAP_DR) && sel_id
		|=> id_reg == ID_CODE)
		else $error("identify code not captured");

	a_bsr_shift: assert property ((state_reg == ST_SHIFT_DR) && sel_bsr
		|=> bsr_reg[BSR_LEN-1] == $past(TDI_IN)
		&& bsr_reg[BSR_LEN-2:0] == $past(bsr_reg[BSR_LEN-1:1]))
		else $error("boundary shift path broken");

	a_bsr_capture: assert property ((state_reg == ST_CAP_DR) && sel_bsr
		|=> bsr_reg == $past(ring_sync))
		else $error("ring snapshot not captured");

	a_float_req: assert property ((ir_reg == INS_EXT_TEST) || (ir_reg == INS_SAMPLE_Z)
		|=> float_req_reg)
		else $error("float request missing");

	a_tdo_float: assert property (@(negedge TCK_IN) disable iff (tap_rst)
		!shifting |=> !tdo_oe_reg)
		else $error("serial output driven outside shift");

	a_tdo_value: assert property (@(negedge TCK_IN) disable iff (tap_rst)
		shifting |=> tdo_oe_reg && (tdo_reg == $past(tdo_src)))
		else $error("serial output not the selected lsb");

endmodule // sbt_tap

/* testbench/sbt_scan_ctl.sv */
// scan controller model that drives the test port link
`timescale 1ns/1ps

module sbt_scan_ctl
(
	// link towards the test port
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	input  wire logic tdo_in,
	input  wire logic tdo_oe_in
);
	// =====================================================================
	// link timing
	// =====================================================================
	localparam realtime HALF = 7.5;

	// idle link: clock parked low, mode select at its pull-up level
	initial
	begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h1;
	end

	// one test clock period; inputs change after the fall, output read at the rise
	task automatic pulse(input logic tms, input logic tdi, output logic tdo, output logic oe);
	begin
		tms_out <= tms;
		tdi_out <= tdi;
		#(HALF);
		tck_out <= 1'h1;
		tdo = tdo_in;
		oe = tdo_oe_in;
		#(HALF);
		tck_out <= 1'h0;
	end
	endtask
endmodule // sbt_scan_ctl

/* testbench/sbt_tap_tb_top.sv */
// self-checking bench for the scan test port
`timescale 1ns/1ps

module sbt_tap_tb_top;
	import sbt_pkg::*;
	// =====================================================================
	// bench setup
	// =====================================================================
	localparam int                  BSR_N  = 12;            // short ring keeps scans brief
	localparam logic [ID_WIDTH-1:0] ID_VAL = 32'h1357_9bdf; // value is arbitrary
	localparam logic [63:0]         PAT    = 64'hc3a5_96f0_0f69_5a3c;
	logic             clock;
	logic             reset;
	logic             tck;
	logic             tms;
	logic             tdi;
	logic             tdo;
	logic             tdo_oe;
	logic             float_out;
	logic [BSR_N-1:0] ring;
	logic [63:0]      seen;
	int               bad_count;
	int               check_count;

	// system clock
	initial
	begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	sbt_tap #(.BSR_LEN(BSR_N), .ID_CODE(ID_VAL)) dut
	(
		.CLOCK_IN          (clock),
		.RESET_IN          (reset),
		.TCK_IN            (tck),
		.TMS_IN            (tms),
		.TDI_IN            (tdi),
		.TDO_OUT           (tdo),
		.TDO_OE_OUT        (tdo_oe),
		.RING_IN           (ring),
		.FLOAT_OUTPUTS_OUT (float_out)
	);

	sbt_scan_ctl ctl
	(
		.tck_out   (tck),
		.tms_out   (tms),
		.tdi_out   (tdi),
		.tdo_in    (tdo),
		.tdo_oe_in (tdo_oe)
	);

	// =====================================================================
	// shared tasks
	// =====================================================================
	task automatic give_verdict;
	begin
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
	begin
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	end
	endtask

	// idle pulses with mode select low
	task automatic idle(input int n);
		logic o;
		logic e;
	begin
		repeat (n) ctl.pulse(1'h0, 1'h0, o, e);
	end
	endtask

	// full scan from idle back to idle; lsb of dout left the port first
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
			output logic [63:0] dout);
		logic o;
		logic e;
	begin
		dout = '0;
		ctl.pulse(1'h1, 1'h0, o, e);
		if (ir)
			ctl.pulse(1'h1, 1'h0, o, e);
		ctl.pulse(1'h0, 1'h0, o, e);
		ctl.pulse(1'h0, 1'h0, o, e);
		for (int i = 0; i < n; i++)
		begin
			ctl.pulse(i == n - 1, din[i], o, e);
			dout[i] = o;
			check("drive enable while shifting", 64'h1, {63'h0, e});
		end
		ctl.pulse(1'h1, 1'h0, o, e);
		check("drive enable after shifting", 64'h0, {63'h0, e});
		ctl.pulse(1'h0, 1'h0, o, e);
	end
	endtask

	// loads an instruction, then checks capture pattern and output float
	task automatic load_ir(input logic [2:0] code);
		logic fl;
	begin
		scan(1'h1, IR_WIDTH, {61'h0, code}, seen);
		check("ir capture", {61'h0, IR_CAPTURE_MSB, IR_CAPTURE_LOW}, seen);
		idle(2);
		repeat (6) @(negedge clock);
		fl = (code == INS_EXT_TEST) || (code == INS_SAMPLE_Z);
		check("float outputs", {63'h0, fl}, {63'h0, float_out});
	end
	endtask

	// =====================================================================
	// scenarios
	// =====================================================================
	// power-up reset floats the output and selects the identity register
	task automatic t_power_up;
		logic o;
		logic e;
	begin
		repeat (4) ctl.pulse(1'h1, 1'h1, o, e);
		check("drive enable in reset", 64'h0, {63'h0, tdo_oe});
		check("float in reset", 64'h0, {63'h0, float_out});
		@(posedge clock);
		reset <= 1'h0;
		repeat (2) ctl.pulse(1'h1, 1'h1, o, e);
		idle(1);
		scan(1'h0, ID_WIDTH, PAT, seen);
		check("identity after power-up", {32'h0, ID_VAL}, seen);
	end
	endtask

	// every code but the reserved 3, 5 and 6: length and content of the selected path
	task automatic t_codes;
		logic [63:0] exp;
		logic [63:0] mask;
		int          n;
	begin
		for (int c = 0; c < 8; c++)
		begin
			// reserved codes are never loaded by a well-behaved controller
			if (c == 3 || c == 5 || c == 6)
				continue;
			@(posedge clock);
			ring <= 12'h5a3 ^ {c[2:0], 9'h0c6};
			idle(2);
			load_ir(c[2:0]);
			if (c == 0 || c == 2 || c == 4)
			begin
				n = 2 * BSR_N;
				exp = (PAT << BSR_N) | 64'(ring);
			end
			else if (c == 1)
			begin
				n = ID_WIDTH;
				exp = {32'h0, ID_VAL};
			end
			else
			begin
				n = 8;
				exp = {PAT[62:0], BYPASS_CAPTURE};
			end
			mask = (64'h1 << n) - 64'h1;
			scan(1'h0, n, PAT, seen);
			check("data path", exp & mask, seen);
		end
	end
	endtask

	// five high mode-select edges from shift-dr return to reset
	task automatic t_tms_reset;
		logic o;
		logic e;
	begin
		load_ir(INS_EXT_TEST);
		ctl.pulse(1'h1, 1'h0, o, e);
		ctl.pulse(1'h0, 1'h0, o, e);
		ctl.pulse(1'h0, 1'h0, o, e);
		repeat (RESET_TMS_EDGES) ctl.pulse(1'h1, 1'h0, o, e);
		idle(2);
		repeat (6) @(negedge clock);
		check("float after link reset", 64'h0, {63'h0, float_out});
		scan(1'h0, ID_WIDTH, PAT, seen);
		check("identity after link reset", {32'h0, ID_VAL}, seen);
	end
	endtask

	// =====================================================================
	// main sequence and watchdog
	// =====================================================================
	initial
	begin
		reset = 1'h1;
		ring = '0;
		bad_count = 0;
		check_count = 0;
		t_power_up();
		t_codes();
		t_tms_reset();
		give_verdict();
	end

	// cuts a hang short
	initial
	begin
		#200000;
		bad_count++;
		$display("FAIL watchdog expected finish seen hang");
		give_verdict();
	end
endmodule // sbt_tap_tb_top
